// ===== rtl/rcf_reading_filter.sv
// conversion sequencer and per-function moving-average filter of the measurement path
// Contract
// - integration setting limited to 0.002..15 cycles at 60 Hz, 0.002..12 at 50 Hz
// - integration setting kept per function; the selected function's value is used
// - auto reference on: 5 conversions concurrent, 4 current, 3 voltage
// - auto reference off: 2 conversions concurrent, 1 current or voltage
// - every conversion integrates for the configured aperture
// - line period is 16.67 ms at 60 Hz and 20 ms at 50 Hz
// - auto reference setting applies to all functions alike
// - per-function digits 4.5, 5.5 or 6.5, reset value 6.5
// - digits coded 4, 5 and 6
// - digits never change timing, accuracy or reading value
// - digits change takes effect from the next reading
// - filter pushes newest, drops oldest, averages the whole stack
// - first conversion after reset, clear, filter enable or depth change fills every stack location
// - an output is produced after every conversion, from the first on
// - filter depth accepted from 2 to 100
// - conversion inside the window is pushed and the stack average output
// - conversion outside the window refills the stack and is output alone
// - window limit is percentage times active range full scale
// - window choices 0.01, 0.1, 1, 10, 100 percent; 100 disables the check
// - concurrent function filters current only, voltage passes raw
module rcf_reading_filter #(
  parameter int unsigned LINE60_CYC = rcf_pkg::LINE60_CYCLES,
  parameter int unsigned LINE50_CYC = rcf_pkg::LINE50_CYCLES
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_trigger,
  input  rcf_pkg::rcf_fn_t             i_function,
  input  wire logic                    i_line_50hz,
  input  wire logic                    i_auto_reference_enable,
  input  rcf_pkg::rcf_fcfg_t [2:0]     i_cfg,
  input  wire logic                    i_filter_clear,
  input  wire logic                    i_digits_wr,
  input  rcf_pkg::rcf_fn_t             i_digits_fn,
  input  wire logic [2:0]              i_digits_val,
  output rcf_pkg::rcf_conv_t           o_conv,
  input  wire logic                    i_conv_done,
  input  wire logic [23:0]             i_conv_data,
  output logic                         o_busy,
  output logic                         o_setting_clamped,
  output logic                         o_rd_valid,
  output rcf_pkg::rcf_reading_t        o_rd,
  input  wire logic                    i_rd_ready
);
  import rcf_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_INTEG = 5'h02,
    S_WAIT  = 5'h04,
    S_FILT  = 5'h08,
    S_PUSH  = 5'h10
  } rcf_state_e_t;

  typedef struct packed {
    rcf_state_e_t       state;
    logic               trig_s1;
    logic               trig_s2;
    logic               trig_s3;
    rcf_fn_t            fn;
    logic               az;
    logic [2:0]         digits_snap;
    logic [2:0]         conv_idx;
    logic [2:0]         conv_total;
    logic [31:0]        aperture;
    logic [31:0]        count;
    rcf_conv_t          conv;
    logic [23:0]        v_raw;
    logic [23:0]        i_raw;
    logic [2:0][2:0]    digits;
    logic               clamped;
    logic [2:0][30:0]   sum;
    logic [2:0][23:0]   avg;
    logic [2:0][23:0]   fill;
    logic [2:0][6:0]    ptr;
    logic [2:0][6:0]    written;
    logic [2:0][6:0]    depth_used;
    logic [2:0]         empty;
    rcf_reading_t [1:0] res;
    logic               push_idx;
    logic               push_last;
    logic               busy;
  } rcf_st_t;

  rcf_st_t      r_reg;
  rcf_st_t      r_next;
  logic [23:0]  stack_mem [3][DEPTH_WORDS];
  logic         mem_we;
  logic [1:0]   mem_sel;
  logic [6:0]   mem_ptr;
  logic [23:0]  mem_data;
  logic         trig_edge;
  logic         fifo_ready;
  logic [1:0]   sel;
  logic [23:0]  sample;
  logic [6:0]   depth;
  logic [23:0]  oldest;
  logic         restart;
  logic [23:0]  fres;
  logic [13:0]  cyc_eff;

  function automatic logic [13:0] clamp_cycles(input logic [13:0] c, input logic l50);
    logic [13:0] hi;
    hi = l50 ? CYC_MAX_50 : CYC_MAX_60;
    if (c < CYC_MIN) begin
      return CYC_MIN;
    end else if (c > hi) begin
      return hi;
    end
    return c;
  endfunction

  function automatic logic [31:0] aperture_of(input logic [13:0] c, input logic [31:0] per);
    logic [45:0] p;
    p = ({32'h0000_0000, c} * {14'h0000, per}) / PLC_SCALE;
    return (p == '0) ? 32'h0000_0001 : p[31:0];
  endfunction

  function automatic logic [2:0] conv_count(input rcf_fn_t f, input logic a);
    if (f == FN_CONC) begin
      return a ? NCONV_CONC_AZ : NCONV_CONC;
    end else if (f == FN_CURR) begin
      return a ? NCONV_CURR_AZ : NCONV_SINGLE;
    end
    return a ? NCONV_VOLT_AZ : NCONV_SINGLE;
  endfunction

  // references first (zero and gain alternating), user conversions last
  function automatic rcf_kind_t kind_of(input rcf_fn_t f, input logic [2:0] idx,
                                        input logic [2:0] total);
    logic [2:0] users;
    users = (f == FN_CONC) ? NCONV_CONC : NCONV_SINGLE;
    if (idx < 3'(total - users)) begin
      return idx[0] ? CK_GAIN : CK_ZERO;
    end else if (f == FN_CONC) begin
      return (idx == 3'(total - 3'h2)) ? CK_VOLT : CK_CURR;
    end
    return (f == FN_CURR) ? CK_CURR : CK_VOLT;
  endfunction

  function automatic logic [6:0] clamp_depth(input logic [6:0] d);
    if (d < DEPTH_MIN) begin
      return DEPTH_MIN;
    end else if (d > DEPTH_MAX) begin
      return DEPTH_MAX;
    end
    return d;
  endfunction

  function automatic logic outside_window(input logic [23:0] x, input logic [23:0] ref_v,
                                          input logic [2:0] code, input logic [23:0] fs);
    logic signed [24:0] diff;
    logic        [24:0] mag;
    logic        [23:0] lim;
    diff = $signed({x[23], x}) - $signed({ref_v[23], ref_v});
    mag  = diff[24] ? 25'(-diff) : 25'(diff);
    if (code == WIN_0P01) begin
      lim = fs / WIN_DIV_0P01;
    end else if (code == WIN_0P1) begin
      lim = fs / WIN_DIV_0P1;
    end else if (code == WIN_1) begin
      lim = fs / WIN_DIV_1;
    end else if (code == WIN_10) begin
      lim = fs / WIN_DIV_10;
    end else begin
      return 1'b0;
    end
    return mag > {1'b0, lim};
  endfunction

  assign trig_edge  = r_reg.trig_s2 && !r_reg.trig_s3;
  assign sel        = (r_reg.fn == FN_VOLT) ? 2'h0 : ((r_reg.fn == FN_CURR) ? 2'h1 : 2'h2);
  assign sample     = (r_reg.fn == FN_VOLT) ? r_reg.v_raw : r_reg.i_raw;
  assign depth      = clamp_depth(i_cfg[sel].depth);
  assign oldest     = (r_reg.written[sel] >= depth) ? stack_mem[sel][r_reg.ptr[sel]]
                                                    : r_reg.fill[sel];
  assign restart    = r_reg.empty[sel] || (r_reg.depth_used[sel] != depth) ||
                      outside_window(sample, r_reg.avg[sel], i_cfg[sel].window,
                                     i_cfg[sel].full_scale);
  assign cyc_eff    = clamp_cycles(i_cfg[i_function].line_cycles, i_line_50hz);

  always_comb begin
    r_next          = r_reg;
    mem_we          = 1'b0;
    mem_sel         = sel;
    mem_ptr         = r_reg.ptr[sel];
    mem_data        = sample;
    fres            = sample;
    r_next.trig_s1  = i_trigger;
    r_next.trig_s2  = r_reg.trig_s1;
    r_next.trig_s3  = r_reg.trig_s2;
    r_next.conv.start = 1'b0;
    if (i_digits_wr && (i_digits_val >= DIG_45) && (i_digits_val <= DIG_65)) begin
      r_next.digits[i_digits_fn] = i_digits_val;
    end
    case (r_reg.state)
      S_IDLE: begin
        if (trig_edge) begin
          r_next.fn          = i_function;
          r_next.az          = i_auto_reference_enable;
          r_next.digits_snap = r_reg.digits[i_function];
          r_next.clamped     = cyc_eff != i_cfg[i_function].line_cycles;
          r_next.aperture    = aperture_of(cyc_eff, i_line_50hz ? 32'(LINE50_CYC)
                                                                : 32'(LINE60_CYC));
          r_next.conv_total  = conv_count(i_function, i_auto_reference_enable);
          r_next.conv_idx    = 3'h0;
          r_next.count       = r_next.aperture;
          r_next.conv.start  = 1'b1;
          r_next.conv.integrate = 1'b1;
          r_next.conv.kind   = kind_of(i_function, 3'h0, r_next.conv_total);
          r_next.busy        = 1'b1;
          r_next.state       = S_INTEG;
        end
      end
      S_INTEG: begin
        // every conversion, reference or user, gets the same aperture
        if (r_reg.count <= 32'h0000_0001) begin
          r_next.conv.integrate = 1'b0;
          r_next.state          = S_WAIT;
        end else begin
          r_next.count = 32'(r_reg.count - 1'b1);
        end
      end
      S_WAIT: begin
        if (i_conv_done) begin
          if (r_reg.conv.kind == CK_VOLT) begin
            r_next.v_raw = i_conv_data;
          end else if (r_reg.conv.kind == CK_CURR) begin
            r_next.i_raw = i_conv_data;
          end
          if (r_reg.conv_idx == 3'(r_reg.conv_total - 3'h1)) begin
            r_next.state = S_FILT;
          end else begin
            r_next.conv_idx       = 3'(r_reg.conv_idx + 3'h1);
            r_next.count          = r_reg.aperture;
            r_next.conv.start     = 1'b1;
            r_next.conv.integrate = 1'b1;
            r_next.conv.kind      = kind_of(r_reg.fn, r_next.conv_idx, r_reg.conv_total);
            r_next.state          = S_INTEG;
          end
        end
      end
      S_FILT: begin
        if (!i_cfg[sel].filt_en) begin
          r_next.empty[sel] = 1'b1;
        end else if (restart) begin
          r_next.sum[sel]        = 31'($signed({{7{sample[23]}}, sample}) *
                                       $signed({24'h00_0000, depth}));
          r_next.fill[sel]       = sample;
          r_next.written[sel]    = 7'h00;
          r_next.ptr[sel]        = 7'h00;
          r_next.avg[sel]        = sample;
          r_next.empty[sel]      = 1'b0;
          r_next.depth_used[sel] = depth;
        end else begin
          mem_we                 = 1'b1;
          r_next.sum[sel]        = 31'(r_reg.sum[sel] - {{7{oldest[23]}}, oldest} +
                                       {{7{sample[23]}}, sample});
          r_next.ptr[sel]        = (r_reg.ptr[sel] == 7'(depth - 7'h01)) ? 7'h00
                                 : 7'(r_reg.ptr[sel] + 7'h01);
          r_next.written[sel]    = (r_reg.written[sel] >= depth) ? r_reg.written[sel]
                                 : 7'(r_reg.written[sel] + 7'h01);
          r_next.avg[sel]        = 24'($signed(r_next.sum[sel]) /
                                       $signed({24'h00_0000, depth}));
          fres                   = r_next.avg[sel];
        end
        // digits ride along as a tag only, the value is untouched
        if (r_reg.fn == FN_CONC) begin
          r_next.res[0]    = '{r_reg.v_raw, r_reg.fn, 1'b0, r_reg.digits_snap, 1'b0};
          r_next.res[1]    = '{fres, r_reg.fn, 1'b1, r_reg.digits_snap,
                               i_cfg[sel].filt_en};
          r_next.push_last = 1'b1;
        end else begin
          r_next.res[0]    = '{fres, r_reg.fn, r_reg.fn == FN_CURR, r_reg.digits_snap,
                               i_cfg[sel].filt_en};
          r_next.push_last = 1'b0;
        end
        r_next.push_idx = 1'b0;
        r_next.state    = S_PUSH;
      end
      S_PUSH: begin
        // a full buffer stalls the sequencer, no reading is dropped
        if (fifo_ready) begin
          if (r_reg.push_idx == r_reg.push_last) begin
            r_next.busy  = 1'b0;
            r_next.state = S_IDLE;
          end else begin
            r_next.push_idx = 1'b1;
          end
        end
      end
      default: begin
        r_next.state = S_IDLE;
      end
    endcase
    if (i_filter_clear) begin
      r_next.empty = 3'h7;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg        <= '0;
      r_reg.state  <= S_IDLE;
      r_reg.digits <= {DIG_RST, DIG_RST, DIG_RST};
      r_reg.empty  <= 3'h7;
    end else if (i_clk_en) begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && mem_we) begin
      stack_mem[mem_sel][mem_ptr] <= mem_data;
    end
  end

  rcf_fifo #(
    .W     ($bits(rcf_reading_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (r_reg.state == S_PUSH),
    .i_in_data   (r_reg.res[r_reg.push_idx]),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_rd_valid),
    .o_out_data  (o_rd),
    .i_out_ready (i_rd_ready)
  );

  assign o_conv            = r_reg.conv;
  assign o_busy            = r_reg.busy;
  assign o_setting_clamped = r_reg.clamped;

  logic [31:0] integ_len;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      integ_len <= '0;
    end else if (i_clk_en) begin
      integ_len <= r_reg.conv.integrate ? 32'(integ_len + 1'b1) : 32'h0000_0000;
    end
  end

  sequence s_trig_taken;
    r_reg.state == S_IDLE && trig_edge && i_clk_en;
  endsequence
  sequence s_conv_begin;
    r_reg.conv.start && r_reg.conv.integrate && r_reg.conv_idx == 3'h0;
  endsequence

  a_trig_starts_conv: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_trig_taken |=> s_conv_begin) else $error("trigger did not start a conversion");
  a_aperture_length: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(r_reg.conv.integrate) |-> integ_len == r_reg.aperture)
    else $error("integration length differs from aperture");
  a_conv_count_ok: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.state == S_FILT |-> r_reg.conv_idx == 3'(conv_count(r_reg.fn, r_reg.az) - 3'h1))
    else $error("wrong number of conversions per reading");
  a_no_ref_when_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.conv.start && !r_reg.az |-> r_reg.conv.kind inside {CK_VOLT, CK_CURR})
    else $error("reference conversion with auto reference off");
  a_digits_legal: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.digits[i_digits_fn] >= DIG_45 && r_reg.digits[i_digits_fn] <= DIG_65)
    else $error("digit setting out of range");
  a_filter_off_pass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.state == S_FILT && i_clk_en && !i_cfg[sel].filt_en && r_reg.fn != FN_CONC
    |=> r_reg.res[0].value == $past(sample) && r_reg.empty[$past(sel)])
    else $error("disabled filter altered the reading");
  a_conc_volt_raw: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.state == S_FILT && i_clk_en && r_reg.fn == FN_CONC
    |=> r_reg.res[0].value == r_reg.v_raw && r_reg.res[1].is_current)
    else $error("concurrent voltage was filtered");
  a_restart_single: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.state == S_FILT && i_clk_en && i_cfg[sel].filt_en && restart && !i_filter_clear
    |=> r_reg.avg[$past(sel)] == $past(sample) && r_reg.written[$past(sel)] == 7'h00)
    else $error("restart did not output the single conversion");
  a_push_stalls: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    r_reg.state == S_PUSH && !fifo_ready |=> r_reg.state == S_PUSH)
    else $error("reading lost while buffer full");
endmodule

// ===== rtl/rcf_pkg.sv
// constants, encodings and carrier types of the reading conditioning filter
package rcf_pkg;
  localparam real         CLK_MHZ          = 10.0;
  localparam real         LINE60_PERIOD_MS = 16.67;
  localparam real         LINE50_PERIOD_MS = 20.0;
  localparam int unsigned LINE60_CYCLES    = int'(LINE60_PERIOD_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned LINE50_CYCLES    = int'(LINE50_PERIOD_MS * 1000.0 * CLK_MHZ);

  // integration setting is carried in thousandths of a line cycle
  localparam logic [45:0] PLC_SCALE  = 46'h0000_0000_03E8;
  localparam logic [13:0] CYC_MIN    = 14'h0002;
  localparam logic [13:0] CYC_MAX_60 = 14'h3A98;
  localparam logic [13:0] CYC_MAX_50 = 14'h2EE0;

  localparam logic [6:0]  DEPTH_MIN   = 7'h02;
  localparam logic [6:0]  DEPTH_MAX   = 7'h64;
  localparam int          DEPTH_WORDS = 100;

  localparam logic [2:0]  DIG_45  = 3'h4;
  localparam logic [2:0]  DIG_55  = 3'h5;
  localparam logic [2:0]  DIG_65  = 3'h6;
  localparam logic [2:0]  DIG_RST = DIG_65;

  localparam logic [2:0]  NCONV_CONC_AZ = 3'h5;
  localparam logic [2:0]  NCONV_CURR_AZ = 3'h4;
  localparam logic [2:0]  NCONV_VOLT_AZ = 3'h3;
  localparam logic [2:0]  NCONV_CONC    = 3'h2;
  localparam logic [2:0]  NCONV_SINGLE  = 3'h1;

  localparam logic [2:0]  WIN_0P01 = 3'h0;
  localparam logic [2:0]  WIN_0P1  = 3'h1;
  localparam logic [2:0]  WIN_1    = 3'h2;
  localparam logic [2:0]  WIN_10   = 3'h3;
  localparam logic [2:0]  WIN_100  = 3'h4;
  localparam logic [23:0] WIN_DIV_0P01 = 24'h00_2710;
  localparam logic [23:0] WIN_DIV_0P1  = 24'h00_03E8;
  localparam logic [23:0] WIN_DIV_1    = 24'h00_0064;
  localparam logic [23:0] WIN_DIV_10   = 24'h00_000A;

  localparam int DATA_W     = 24;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    FN_VOLT = 2'h0,
    FN_CURR = 2'h1,
    FN_CONC = 2'h2
  } rcf_fn_t;

  typedef enum logic [1:0] {
    CK_ZERO = 2'h0,
    CK_GAIN = 2'h1,
    CK_VOLT = 2'h2,
    CK_CURR = 2'h3
  } rcf_kind_t;

  typedef struct packed {
    logic [13:0] line_cycles;
    logic        filt_en;
    logic [6:0]  depth;
    logic [2:0]  window;
    logic [23:0] full_scale;
  } rcf_fcfg_t;

  typedef struct packed {
    logic      start;
    logic      integrate;
    rcf_kind_t kind;
  } rcf_conv_t;

  typedef struct packed {
    logic [23:0] value;
    rcf_fn_t     fn;
    logic        is_current;
    logic [2:0]  digits;
    logic        filtered;
  } rcf_reading_t;
endpackage

// ===== rtl/rcf_fifo.sv
// first-in first-out buffer with a registered output stage
module rcf_fifo #(
  parameter int W     = 31,
  parameter int DEPTH = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clk_en,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          out_valid;
    logic [W-1:0]  out_data;
    logic          in_ready;
  } rcf_fifo_st_t;

  rcf_fifo_st_t  r_reg;
  rcf_fifo_st_t  r_next;
  logic [W-1:0]  mem [DEPTH];
  logic          push;
  logic          pop;

  always_comb begin
    r_next = r_reg;
    push   = i_in_valid && r_reg.in_ready;
    pop    = (r_reg.count != '0) && (!r_reg.out_valid || i_out_ready);
    if (pop) begin
      r_next.out_data  = mem[r_reg.rd_ptr];
      r_next.out_valid = 1'b1;
      r_next.rd_ptr    = AW'(r_reg.rd_ptr + 1'b1);
    end else if (i_out_ready) begin
      r_next.out_valid = 1'b0;
    end
    if (push) begin
      r_next.wr_ptr = AW'(r_reg.wr_ptr + 1'b1);
    end
    r_next.count    = (AW + 1)'(r_reg.count + push - pop);
    r_next.in_ready = r_next.count < (AW + 1)'(DEPTH);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg          <= '0;
      r_reg.in_ready <= 1'b1;
    end else if (i_clk_en) begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && push) begin
      mem[r_reg.wr_ptr] <= i_in_data;
    end
  end

  assign o_in_ready  = r_reg.in_ready;
  assign o_out_valid = r_reg.out_valid;
  assign o_out_data  = r_reg.out_data;
endmodule

// ===== verification/rcf_conv_model.sv
// behavioural converter that answers the sequencer's conversions
module rcf_conv_model (
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst_n,
  input  rcf_pkg::rcf_conv_t i_conv,
  input  wire logic [3:0]    i_delay,
  input  wire logic [23:0]   i_volt,
  input  wire logic [23:0]   i_curr,
  output logic               o_done,
  output logic [23:0]        o_data,
  output int                 o_n_conv,
  output int                 o_aperture
);
  timeunit 1ns;
  timeprecision 1ns;
  import rcf_pkg::*;
  logic int_reg;
  int   wait_reg;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_done, o_data, o_n_conv, o_aperture, int_reg, wait_reg} <= '0;
    end else begin
      int_reg <= i_conv.integrate;
      o_done <= 1'b0;
      // data toggles outside done so a stale word is never mistaken for a fresh one
      o_data <= ~o_data;
      if (i_conv.start)
        o_n_conv <= o_n_conv + 1;
      o_aperture <= i_conv.start ? 1 : o_aperture + int'(i_conv.integrate);
      if (int_reg && !i_conv.integrate)
        wait_reg <= int'(i_delay) + 1;
      else if (wait_reg > 1)
        wait_reg <= wait_reg - 1;
      else if (wait_reg == 1) begin
        wait_reg <= 0;
        o_done <= 1'b1;
        o_data <= i_conv.kind == CK_VOLT ? i_volt : i_conv.kind == CK_CURR ? i_curr : ~i_volt;
      end
    end
  end
endmodule

// ===== verification/rcf_reading_filter_tb_top.sv
// self-checking bench: random and corner readings with the converter model behind
module rcf_reading_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rcf_pkg::*;
  localparam int P60 = 80;
  localparam int P50 = 100;
  logic            sys_clk = 1'b0;
  logic            rd_ready = 1'b0;
  logic            rst_n, trig, l50, az, clr, dig_wr, done, rd_mode, busy, clamped, rd_valid;
  logic [2:0]      dig_val;
  logic [3:0]      dly;
  logic [23:0]     volt, curr, data;
  rcf_fn_t         fn, dig_fn;
  rcf_fcfg_t [2:0] cfg;
  rcf_conv_t       conv;
  rcf_reading_t    rd;
  rcf_reading_t    exp_q[$];
  int              n_conv, aper, n_mismatch, check_count, n, st[3][$], last[3];
  int              seed = 32'h0000_4330;
  logic [2:0]      dig[3];
  logic [13:0]     lcs[4] = '{14'h0001, 14'h32C8, 14'h3E80, 14'h2EE0};

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rd_ready <= #5 rd_mode & 1'($random(seed));
  always @(posedge sys_clk)
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      check(rd, exp_q.size() > 0 ? exp_q.pop_front() : '1);

  rcf_reading_filter #(.LINE60_CYC(P60), .LINE50_CYC(P50)) dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_trigger(trig),
    .i_function(fn), .i_line_50hz(l50), .i_auto_reference_enable(az), .i_cfg(cfg),
    .i_filter_clear(clr), .i_digits_wr(dig_wr), .i_digits_fn(dig_fn),
    .i_digits_val(dig_val), .o_conv(conv), .i_conv_done(done), .i_conv_data(data),
    .o_busy(busy), .o_setting_clamped(clamped), .o_rd_valid(rd_valid), .o_rd(rd),
    .i_rd_ready(rd_ready));
  rcf_conv_model conv_model (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_conv(conv), .i_delay(dly), .i_volt(volt),
    .i_curr(curr), .o_done(done), .o_data(data), .o_n_conv(n_conv), .o_aperture(aper));

  task automatic tick(int k);
    repeat (k) @(posedge sys_clk);
    #5;
  endtask

  task automatic check(logic [63:0] got, logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("counts: checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_busy(logic want, int lim);
    for (int i = 0; i < lim && busy !== want; i++) tick(1);
    if (busy !== want) begin
      n_mismatch++;
      test_done();
    end
  endtask

  function automatic int ap_exp(int lc);
    int c;
    c = lc < CYC_MIN ? CYC_MIN : lc;
    c = c > (l50 ? CYC_MAX_50 : CYC_MAX_60) ? (l50 ? CYC_MAX_50 : CYC_MAX_60) : c;
    c = c * (l50 ? P50 : P60) / int'(PLC_SCALE);
    return c < 1 ? 1 : c;
  endfunction

  // expected filter output; a depth change shows as a size mismatch and restarts
  function automatic logic [23:0] filt(int s, int x);
    int d, lim;
    logic [2:0] w;
    w = cfg[s].window;
    d = cfg[s].depth < DEPTH_MIN ? DEPTH_MIN : cfg[s].depth > DEPTH_MAX ? DEPTH_MAX : cfg[s].depth;
    lim = cfg[s].full_scale / (w == WIN_0P01 ? WIN_DIV_0P01 : w == WIN_0P1 ? WIN_DIV_0P1 :
          w == WIN_1 ? WIN_DIV_1 : WIN_DIV_10);
    if (!cfg[s].filt_en || st[s].size() != d || (w < WIN_100 && (x - last[s] > lim ||
        last[s] - x > lim)))
      st[s].delete();
    if (!cfg[s].filt_en)
      return x[23:0];
    st[s].push_front(x);
    while (st[s].size() < d) st[s].push_front(x);
    if (st[s].size() > d)
      void'(st[s].pop_back());
    last[s] = st[s].sum() / d;
    return 24'(last[s]);
  endfunction

  task automatic do_read(rcf_fn_t f, logic a, logic [23:0] c, logic hold);
    int n0, nx, ax;
    logic [23:0] v;
    n0 = n_conv;
    nx = f == FN_CONC ? (a ? 5 : 2) : a ? (f == FN_CURR ? 4 : 3) : 1;
    ax = ap_exp(cfg[f].line_cycles);
    fn = f;
    az = a;
    curr = c;
    volt = 24'($random(seed));
    dly = 4'($random(seed));
    v = f == FN_VOLT ? filt(0, $signed(volt)) : volt;
    if (f != FN_CURR)
      exp_q.push_back('{v, f, 1'b0, dig[f], cfg[f].filt_en && f == FN_VOLT});
    if (f != FN_VOLT)
      exp_q.push_back('{filt(f, $signed(c)), f, 1'b1, dig[f], cfg[f].filt_en});
    trig = 1'b1;
    wait_busy(1'b1, 10);
    trig = 1'b0;
    if (hold)
      tick(nx * (ax + 30) + 100);
    else
      wait_busy(1'b0, nx * (ax + 30) + 100);
    if (busy === 1'b1)
      return;
    check(n_conv - n0, nx);
    check(aper, ax);
    check(clamped, cfg[f].line_cycles < CYC_MIN
          || cfg[f].line_cycles > (l50 ? CYC_MAX_50 : CYC_MAX_60));
  endtask

  initial begin
    {rst_n, trig, l50, az, clr, dig_wr, rd_mode, dig_val, dly, volt, curr} = '0;
    fn = FN_VOLT;
    dig_fn = FN_VOLT;
    dig = '{3'h6, 3'h6, 3'h6};
    for (int i = 0; i < 3; i++) cfg[i] = '{14'h0064, 1'b1, 7'h04, WIN_1, 24'h80_0000};
    tick(2);
    rst_n = 1'b1;
    rd_mode = 1'b1;
    for (int i = 0; i < 12; i++) begin
      l50 = i[0];
      do_read(rcf_fn_t'(i % 3), i[1], 24'h10_0000 + 24'($random(seed) % 64), 1'b0);
    end
    for (int i = 3; i < 8; i++) begin
      dig_fn = rcf_fn_t'(i % 3);
      dig_val = 3'(i);
      dig_wr = 1'b1;
      tick(1);
      dig_wr = 1'b0;
      dig[i % 3] = (i > 3 && i < 7) ? 3'(i) : dig[i % 3];
      do_read(rcf_fn_t'(i % 3), 1'b0, 24'h10_0010, 1'b0);
    end
    cfg[1].line_cycles = 14'h00C8;
    for (int w = 0; w < 5; w++) begin
      cfg[1].window = 3'(w);
      cfg[1].depth = w == 4 ? 7'h78 : 7'h01 + 7'(w);
      repeat (4) do_read(FN_CURR, 1'b0, 24'h10_0000 + 24'($random(seed) % 2000), 1'b0);
    end
    cfg[2].filt_en = 1'b0;
    cfg[1].filt_en = 1'b0;
    do_read(FN_CONC, 1'b0, 24'h20_0000, 1'b0);
    do_read(FN_CURR, 1'b0, 24'h20_0080, 1'b0);
    cfg[1].filt_en = 1'b1;
    cfg[2].filt_en = 1'b1;
    do_read(FN_CONC, 1'b1, 24'h20_0100, 1'b0);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    foreach (st[s]) st[s].delete();
    do_read(FN_CURR, 1'b0, 24'h20_0200, 1'b0);
    foreach (lcs[k]) begin
      l50 = k[0];
      cfg[0].line_cycles = lcs[k];
      do_read(FN_VOLT, 1'b1, 24'h00_0000, 1'b0);
    end
    rd_mode = 1'b0;
    cfg[0].line_cycles = 14'h0064;
    for (n = 0; n < 24 && busy !== 1'b1; n++) do_read(FN_VOLT, 1'b0, 24'h00_0000, 1'b1);
    check({busy, n > 16}, 2'b11);
    rd_mode = 1'b1;
    wait_busy(1'b0, 2000);
    for (n = 0; n < 500 && exp_q.size() > 0; n++) tick(1);
    check(exp_q.size(), 0);
    test_done();
  end
endmodule
